// File: include/ring_consts.vh
// Constants for the ringing waveform generator: register map, fields, codes and timing.
// Assumes a 20 MHz system clock and a plain strobe register port with 8-bit byte addresses.
`ifndef RING_CONSTS_VH
`define RING_CONSTS_VH

// ==========================================================
// Register byte addresses
`define A_CONTROL 8'h00
`define A_LINE_STATE 8'h04
`define A_ON_TIMER 8'h08
`define A_OFF_TIMER 8'h0C
`define A_PEAK_SCALE 8'h10
`define A_PHASE_INIT 8'h14
`define A_STEP_UPPER 8'h18
`define A_STEP_LOWER 8'h1C
`define A_COMMON_MODE 8'h20
`define A_OVERHEAD 8'h24
`define A_LEAD_LEVELS 8'h28
`define A_DC_SHIFT 8'h38

// ==========================================================
// Control word fields
`define F_TRAP 0
`define F_ON_EN 1
`define F_OFF_EN 2
`define F_SINGLE_LEAD 3
`define F_SWAP_LEAD 4
`define F_TRIP_SEEN 5
`define F_RING_ON 6
`define CONTROL_RW_MSB 4

// ==========================================================
// Line state codes
`define LS_OPEN 3'h0
`define LS_ACTIVE 3'h1
`define LS_ONHOOK_TX 3'h2
`define LS_RINGING 3'h4

// ==========================================================
// Coefficient fields
`define STEP_FIELD_MSB 14
`define STEP_FIELD_LSB 3
`define TRAP_STEP_MSB 7
`define AMP_SHIFT 7
`define HALF_PERIOD_SHIFT 3
`define TRAP_STEP_LSB 12

// Centre of single-lead ringing, -80 V in 160.8 V full-scale units.
`define UNB_CENTER 16'h3FAE

// ==========================================================
// Timing
`define CLK_PERIOD_NS 50
`define SAMPLE_PERIOD_NS 125000
`define SAMPLE_CYCLES (`SAMPLE_PERIOD_NS / `CLK_PERIOD_NS)
`define SINE_PERIOD_NS 1000000
`define SINE_DIV (`SINE_PERIOD_NS / `SAMPLE_PERIOD_NS)
// Last count of each tick divider, sized to the counter that is compared with it.
`define SAMPLE_LAST 12'h9C3
`define SINE_LAST 4'h7

`endif

// File: logic/cadence_timer.v
// One cadence timer counting 125 us ticks down from a loaded value.
// Assumes the caller pulses load and tick for one cycle each.
`timescale 1ns/1ns
`default_nettype none

module cadence_timer (
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire load_i,
	input wire tick_i,
	input wire [15:0] value_i,
	output wire expired_o
);
	reg [15:0] count;
	reg armed;

	// ==========================================================
	// Counter
	always @(posedge clk_i) begin
		if (rst_i) begin
			count <= 16'h0000;
			armed <= 1'b0;
		end else if (ce_i) begin
			if (load_i) begin
				count <= value_i;
				armed <= 1'b1;
			end else if (tick_i && armed && count != 16'h0000) begin
				count <= count - 16'h0001;
			end
		end
	end

	assign expired_o = armed && count == 16'h0000 && !load_i;
endmodule // cadence_timer

`default_nettype wire

// File: logic/ring_gen.v
// Ringing waveform generator for one line channel, with cadence control and lead drive.
// Assumes a 20 MHz clock, synchronous inputs and a strobe register port with no wait states.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
`include "ring_consts.vh"
`default_nettype none

module ring_gen (
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire [7:0] addr_i,
	input wire [15:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [15:0] rdata_o,
	input wire ring_trip_i,
	output reg [15:0] tip_level_o,
	output reg [15:0] ring_level_o,
	output reg [2:0] line_state_o,
	output reg ring_relay_o
);
	localparam ST_IDLE = 2'b00;
	localparam ST_ON = 2'b01;
	localparam ST_OFF = 2'b10;

	// ==========================================================
	// Helpers
	function [15:0] sat16;
		input signed [17:0] v;
		begin
			if (v > 18'sh07FFF) begin
				sat16 = 16'h7FFF;
			end else if (v < -18'sh08000) begin
				sat16 = 16'h8000;
			end else begin
				sat16 = v[15:0];
			end
		end
	endfunction

	function signed [17:0] sx;
		input [15:0] v;
		begin
			sx = {{2{v[15]}}, v};
		end
	endfunction

	// ==========================================================
	// Registers
	reg [`CONTROL_RW_MSB:0] control;
	reg [2:0] line_state_reg;
	reg [15:0] on_time;
	reg [15:0] off_time;
	reg [15:0] peak_scale;
	reg [15:0] phase_init;
	reg [15:0] step_upper;
	reg [15:0] step_lower;
	reg [15:0] common_mode;
	reg [15:0] overhead;
	reg [15:0] dc_shift;
	reg trip_seen;
	reg [1:0] state;
	reg [1:0] next_state;
	reg [11:0] fast_count;
	reg [3:0] slow_count;
	reg tick_fast;
	reg tick_slow;
	reg load_on;
	reg load_off;
	reg start_wave;
	reg [15:0] next_tip;
	reg [15:0] next_ring;
	reg [15:0] next_rdata;
	reg signed [17:0] wave_sum;
	reg signed [17:0] unb_point;

	wire ring_sel;
	wire ring_write;
	wire on_expired;
	wire off_expired;
	wire [15:0] sample;
	wire [23:0] coeff;
	wire wave_run;

	assign ring_write = wr_i && addr_i == `A_LINE_STATE && wdata_i[2:0] == `LS_RINGING;
	assign ring_sel = line_state_reg == `LS_RINGING;
	assign wave_run = state == ST_ON;
	assign coeff = {step_upper[`STEP_FIELD_MSB:`STEP_FIELD_LSB],
		step_lower[`STEP_FIELD_MSB:`STEP_FIELD_LSB]};

	// ==========================================================
	// Register writes
	always @(posedge clk_i) begin
		if (rst_i) begin
			control <= 5'h00;
			line_state_reg <= `LS_OPEN;
			on_time <= 16'h0000;
			off_time <= 16'h0000;
			peak_scale <= 16'h0000;
			phase_init <= 16'h0000;
			step_upper <= 16'h0000;
			step_lower <= 16'h0000;
			common_mode <= 16'h0000;
			overhead <= 16'h0000;
			dc_shift <= 16'h0000;
			trip_seen <= 1'b0;
		end else if (ce_i) begin
			if (wr_i) begin
				case (addr_i)
					`A_CONTROL: control <= wdata_i[`CONTROL_RW_MSB:0];
					`A_LINE_STATE: line_state_reg <= wdata_i[2:0];
					`A_ON_TIMER: on_time <= wdata_i;
					`A_OFF_TIMER: off_time <= wdata_i;
					`A_PEAK_SCALE: peak_scale <= wdata_i;
					`A_PHASE_INIT: phase_init <= wdata_i;
					`A_STEP_UPPER: step_upper <= wdata_i;
					`A_STEP_LOWER: step_lower <= wdata_i;
					`A_COMMON_MODE: common_mode <= wdata_i;
					`A_OVERHEAD: overhead <= wdata_i;
					`A_DC_SHIFT: dc_shift <= wdata_i;
					default: ;
				endcase
			end
			// A trip ends ringing through the line state; the set beats a clear.
			if (ring_trip_i && ring_sel) begin
				trip_seen <= 1'b1;
				line_state_reg <= `LS_ACTIVE;
			end else if (wr_i && addr_i == `A_CONTROL && wdata_i[`F_TRIP_SEEN]) begin
				trip_seen <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Sample ticks: 125 us base tick, 1 kHz tick every eighth one
	always @(posedge clk_i) begin
		if (rst_i) begin
			fast_count <= 12'h000;
			slow_count <= 4'h0;
			tick_fast <= 1'b0;
			tick_slow <= 1'b0;
		end else if (ce_i) begin
			tick_fast <= 1'b0;
			tick_slow <= 1'b0;
			if (fast_count == `SAMPLE_LAST) begin
				fast_count <= 12'h000;
				tick_fast <= 1'b1;
				if (slow_count == `SINE_LAST) begin
					slow_count <= 4'h0;
					tick_slow <= 1'b1;
				end else begin
					slow_count <= slow_count + 4'h1;
				end
			end else begin
				fast_count <= fast_count + 12'h001;
			end
		end
	end

	// ==========================================================
	// Cadence state machine, shared by both waveshapes
	always @* begin
		next_state = state;
		load_on = 1'b0;
		load_off = 1'b0;
		start_wave = 1'b0;
		case (state)
			ST_IDLE: begin
				if (ring_sel) begin
					next_state = ST_ON;
					load_on = 1'b1;
					start_wave = 1'b1;
				end
			end
			ST_ON: begin
				if (!ring_sel) begin
					next_state = ST_IDLE;
				end else if (control[`F_ON_EN] && on_expired) begin
					next_state = ST_OFF;
					load_off = 1'b1;
				end
			end
			ST_OFF: begin
				if (!ring_sel) begin
					next_state = ST_IDLE;
				end else if (control[`F_OFF_EN] && off_expired) begin
					next_state = ST_ON;
					load_on = 1'b1;
					start_wave = 1'b1;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		// Rewriting the ringing code restarts the cycle from the on period.
		if (ring_write) begin
			next_state = ST_ON;
			load_on = 1'b1;
			start_wave = 1'b1;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
		end else if (ce_i) begin
			state <= next_state;
		end
	end

	cadence_timer u_on_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.load_i(load_on),
		.tick_i(tick_fast),
		.value_i(on_time),
		.expired_o(on_expired)
	);

	cadence_timer u_off_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.load_i(load_off),
		.tick_i(tick_fast),
		.value_i(off_time),
		.expired_o(off_expired)
	);

	tone_core u_tone (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.start_i(start_wave),
		.run_i(wave_run),
		.trap_i(control[`F_TRAP]),
		.tick_fast_i(tick_fast),
		.tick_slow_i(tick_slow),
		.coeff_i(coeff),
		.amp_i(peak_scale),
		.phase_i(phase_init),
		.sample_o(sample)
	);

	// ==========================================================
	// Lead drive
	always @* begin
		wave_sum = sx(sample) + sx(dc_shift);
		unb_point = sx(common_mode) - (-sx(`UNB_CENTER) + sx(dc_shift));
		next_tip = common_mode;
		next_ring = common_mode;
		if (!wave_run) begin
			next_tip = common_mode;
			next_ring = common_mode;
		end else if (control[`F_SINGLE_LEAD] && control[`F_SWAP_LEAD]) begin
			// Offset sign is reversed by software in this mode.
			next_tip = sat16(unb_point + sx(sample));
			next_ring = common_mode;
			// Clipping keeps the swing on one side of the common-mode level.
			if ($signed(unb_point + sx(sample)) < sx(common_mode)) begin
				next_tip = common_mode;
			end
		end else if (control[`F_SINGLE_LEAD]) begin
			next_tip = common_mode;
			next_ring = sat16(unb_point + sx(sample) - sx(overhead));
			if ($signed(unb_point + sx(sample)) < sx(common_mode)) begin
				next_ring = common_mode;
			end
		end else begin
			// Balanced: each lead carries half the swing in opposite phase.
			next_tip = sat16(sx(common_mode) + (wave_sum >>> 1));
			next_ring = sat16(sx(common_mode) - (wave_sum >>> 1) - sx(overhead));
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			tip_level_o <= 16'h0000;
			ring_level_o <= 16'h0000;
			line_state_o <= `LS_OPEN;
			ring_relay_o <= 1'b0;
		end else if (ce_i) begin
			tip_level_o <= next_tip;
			ring_level_o <= next_ring;
			ring_relay_o <= wave_run;
			// Follows the relay, so the reported state never leaves ringing while it still drives.
			if (wave_run) begin
				line_state_o <= `LS_RINGING;
			end else if (ring_sel) begin
				line_state_o <= `LS_ONHOOK_TX;
			end else begin
				line_state_o <= line_state_reg;
			end
		end
	end

	// ==========================================================
	// Register reads, data one cycle after the strobe
	always @* begin
		case (addr_i)
			`A_CONTROL: next_rdata = {9'h000, wave_run, trip_seen, control};
			`A_LINE_STATE: next_rdata = {13'h0000, line_state_reg};
			`A_ON_TIMER: next_rdata = on_time;
			`A_OFF_TIMER: next_rdata = off_time;
			`A_PEAK_SCALE: next_rdata = peak_scale;
			`A_PHASE_INIT: next_rdata = phase_init;
			`A_STEP_UPPER: next_rdata = step_upper;
			`A_STEP_LOWER: next_rdata = step_lower;
			`A_COMMON_MODE: next_rdata = common_mode;
			`A_OVERHEAD: next_rdata = overhead;
			`A_LEAD_LEVELS: next_rdata = sample;
			`A_DC_SHIFT: next_rdata = dc_shift;
			default: next_rdata = 16'h0000;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 16'h0000;
		end else if (ce_i) begin
			rdata_o <= rd_i ? next_rdata : 16'h0000;
		end
	end
endmodule // ring_gen

`default_nettype wire

// File: logic/tone_core.v
// Waveform engine: two-pole resonator for sine, clamped linear ramp for trapezoid.
// Assumes start pulses while coefficients are stable; ticks are one-cycle pulses.
`timescale 1ns/1ns
`include "ring_consts.vh"
`default_nettype none

module tone_core (
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire start_i,
	input wire run_i,
	input wire trap_i,
	input wire tick_fast_i,
	input wire tick_slow_i,
	input wire [23:0] coeff_i,
	input wire [15:0] amp_i,
	input wire [15:0] phase_i,
	output reg [15:0] sample_o
);
	reg signed [23:0] s1;
	reg signed [23:0] s2;
	reg signed [16:0] level;
	reg rising;
	reg [15:0] half_count;
	wire signed [47:0] prod;
	wire signed [23:0] next_s1;
	wire signed [16:0] step;
	wire signed [16:0] limit;
	wire signed [16:0] up;
	wire signed [16:0] down;

	assign prod = $signed(coeff_i) * s1;
	assign next_s1 = prod[45:22] - s2;
	assign step = {{9{coeff_i[`TRAP_STEP_LSB + `TRAP_STEP_MSB]}},
		coeff_i[`TRAP_STEP_LSB + `TRAP_STEP_MSB:`TRAP_STEP_LSB]};
	assign limit = {amp_i[15], amp_i};
	assign up = level + step;
	assign down = level - step;

	// ==========================================================
	// Sample update
	always @(posedge clk_i) begin
		if (rst_i) begin
			s1 <= 24'h000000;
			s2 <= 24'h000000;
			level <= 17'h00000;
			rising <= 1'b1;
			half_count <= 16'h0000;
			sample_o <= 16'h0000;
		end else if (ce_i) begin
			if (start_i) begin
				s1 <= {amp_i[15], amp_i, 7'h00};
				s2 <= {phase_i[15], phase_i, 7'h00};
				level <= 17'h00000;
				rising <= 1'b1;
				half_count <= phase_i >> `HALF_PERIOD_SHIFT;
				sample_o <= 16'h0000;
			end else if (!run_i) begin
				sample_o <= 16'h0000;
			end else if (trap_i && tick_fast_i) begin
				if (rising) begin
					level <= (up > limit) ? limit : up;
				end else begin
					level <= (down < -limit) ? -limit : down;
				end
				if (half_count == 16'h0000) begin
					half_count <= phase_i >> `HALF_PERIOD_SHIFT;
					rising <= !rising;
				end else begin
					half_count <= half_count - 16'h0001;
				end
				sample_o <= level[15:0];
			end else if (!trap_i && tick_slow_i) begin
				s2 <= s1;
				s1 <= next_s1;
				sample_o <= s1[23:8];
			end
		end
	end
endmodule // tone_core

`default_nettype wire

// File: sim/line_model.sv
// Subscriber line model: an off-hook set trips after a chosen delay of ringing.
// Assumes the relay output shows when ringing current reaches the line.
`timescale 1ns/1ns
`default_nettype none
module line_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic relay_i,
	input wire logic offhook_i,
	input wire logic [15:0] delay_i,
	output logic trip_o
);
	logic [15:0] cnt;
	initial trip_o = 1'b0;
	// Sense current flows only while ringing feeds the line, so trip drops with the relay.
	always @(posedge clk_i) begin
		if (rst_i || !offhook_i || !relay_i) begin
			cnt <= 16'h0000;
			trip_o <= 1'b0;
		end else if (cnt >= delay_i) begin
			trip_o <= 1'b1;
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end
endmodule // line_model
`default_nettype wire

// File: sim/ring_gen_chk.sv
// Port checker for the ringing generator, bound to every ring_gen instance.
// Assumes ce_i stays high and common mode is not rewritten while ringing.
`timescale 1ns/1ns
`default_nettype none
`include "ring_consts.vh"
module ring_gen_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic ring_trip_i,
	input wire logic [15:0] tip_level_o,
	input wire logic [15:0] ring_level_o,
	input wire logic [2:0] line_state_o,
	input wire logic ring_relay_o
);
	// ====
	// Shadows of the lead select bits and the dc offset word.
	logic sl_q;
	logic sw_q;
	logic [15:0] dc_q;
	always @(posedge clk_i) begin
		if (rst_i) begin
			sl_q <= 1'b0;
			sw_q <= 1'b0;
			dc_q <= 16'h0000;
		end else if (wr_i && addr_i == `A_CONTROL) begin
			sl_q <= wdata_i[`F_SINGLE_LEAD];
			sw_q <= wdata_i[`F_SWAP_LEAD];
		end else if (wr_i && addr_i == `A_DC_SHIFT) begin
			dc_q <= wdata_i;
		end
	end
	// ====
	// Properties.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_reset_clears: assert property ($past(rst_i) |-> rdata_o == 16'h0000
		&& !ring_relay_o && line_state_o == 3'h0 && tip_level_o == 16'h0000)
		else $error("outputs not cleared by reset");
	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
		else $error("read data not zero outside a read answer");
	a_read_dc: assert property (rd_i && addr_i == `A_DC_SHIFT |=> rdata_o == $past(dc_q))
		else $error("dc offset read back wrong");
	a_unmapped_read: assert property (rd_i && addr_i == 8'h30 |=> rdata_o == 16'h0000)
		else $error("unmapped read not zero");
	a_start_ring: assert property (wr_i && addr_i == `A_LINE_STATE && wdata_i == 16'h0004
		##1 !ring_trip_i |-> ##1 line_state_o == `LS_RINGING && ring_relay_o)
		else $error("ringing did not start two cycles after the write");
	a_relay_state: assert property (ring_relay_o == (line_state_o == `LS_RINGING))
		else $error("relay and line state disagree");
	a_off_stable: assert property (line_state_o == `LS_ONHOOK_TX
		&& $past(line_state_o) == `LS_ONHOOK_TX && $past(line_state_o, 2) == `LS_ONHOOK_TX
		|-> $stable(tip_level_o) && $stable(ring_level_o))
		else $error("leads moved during on-hook transmission");
	a_trip_stops: assert property (line_state_o == `LS_RINGING && ring_trip_i
		|-> ##[1:3] line_state_o == `LS_ACTIVE && !ring_relay_o)
		else $error("ring trip did not stop ringing");
	a_single_tip: assert property (sl_q && !sw_q && ring_relay_o && $past(ring_relay_o)
		&& $past(ring_relay_o, 2) |-> $stable(tip_level_o))
		else $error("tip lead moved in single lead ringing");
	a_swap_ring: assert property (sl_q && sw_q && ring_relay_o && $past(ring_relay_o)
		&& $past(ring_relay_o, 2) |-> $stable(ring_level_o))
		else $error("ring lead moved in swapped lead ringing");
endmodule // ring_gen_chk
bind ring_gen ring_gen_chk chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ring_trip_i(ring_trip_i),
	.tip_level_o(tip_level_o), .ring_level_o(ring_level_o), .line_state_o(line_state_o),
	.ring_relay_o(ring_relay_o));
`default_nettype wire

// File: sim/tb_top.sv
// Bench for ring_gen: registers, cadence, both shapes, ring trip, lead modes, reset.
// Assumes line_model as the far side and the bound port checker.
`timescale 1ns/1ns
`default_nettype none
`include "ring_consts.vh"
module tb_top;
	logic clk_i, rst_i, ce_i, wr_i, rd_i, ring_trip_i, ring_relay_o, offhook;
	logic [7:0] addr_i;
	logic [15:0] wdata_i, rdata_o, tip_level_o, ring_level_o, dly, d, r0;
	logic [2:0] line_state_o;
	int fails, comparisons, n, ch, bad;
	ring_gen uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ring_trip_i(ring_trip_i),
		.tip_level_o(tip_level_o), .ring_level_o(ring_level_o), .line_state_o(line_state_o),
		.ring_relay_o(ring_relay_o));
	line_model phone (.clk_i(clk_i), .rst_i(rst_i), .relay_i(ring_relay_o), .offhook_i(offhook),
		.delay_i(dly), .trip_o(ring_trip_i));
	// ====
	// Bus and check tasks.
	task close_out;
		begin
			$display("comparisons %0d fails %0d", comparisons, fails);
			if (fails == 0 && comparisons > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task chk(input logic [23:0] s, input logic [23:0] e);
		begin
			comparisons++;
			if (s !== e) begin
				fails++;
				$display("ERROR at %0t: saw %h expected %h", $time, s, e);
			end
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] v);
		begin
			@(posedge clk_i);
			wr_i <= 1'b1;
			addr_i <= a;
			wdata_i <= v;
			@(posedge clk_i);
			wr_i <= 1'b0;
		end
	endtask
	task rd(input logic [7:0] a, output logic [15:0] v);
		begin
			@(posedge clk_i);
			rd_i <= 1'b1;
			addr_i <= a;
			@(posedge clk_i);
			rd_i <= 1'b0;
			#1;
			v = rdata_o;
		end
	endtask
	// A timed-out wait cannot be recovered, so it ends the run at once.
	task wait_ls(input logic [2:0] e, input int b, output int c);
		begin
			c = 0;
			while (line_state_o !== e && c < b) begin
				@(posedge clk_i);
				#1;
				c++;
			end
			if (line_state_o !== e) begin
				fails++;
				$display("ERROR at %0t: line state wait timed out", $time);
				close_out();
			end
		end
	endtask
	// Reads the current sample once per 125 us tick, 2500 cycles apart.
	task series(input int k, input logic [15:0] st, output int c, output int b);
		logic [15:0] p, q;
		begin
			c = 0;
			b = 0;
			rd(`A_LEAD_LEVELS, p);
			repeat (k) begin
				repeat (2498) @(posedge clk_i);
				rd(`A_LEAD_LEVELS, q);
				if (q !== p)
					c++;
				if (q !== p && q - p !== st && p - q !== st)
					b++;
				p = q;
			end
		end
	endtask
	task prog(input logic [15:0] c, amp, ph, up, lo, dc, cm);
		begin
			wr(`A_PEAK_SCALE, amp);
			wr(`A_PHASE_INIT, ph);
			wr(`A_STEP_UPPER, up);
			wr(`A_STEP_LOWER, lo);
			wr(`A_ON_TIMER, 16'h0002);
			wr(`A_OFF_TIMER, 16'h0002);
			wr(`A_DC_SHIFT, dc);
			wr(`A_COMMON_MODE, cm);
			wr(`A_OVERHEAD, 16'h0000);
			wr(`A_CONTROL, c & 16'h0019);
			wr(`A_CONTROL, c);
		end
	endtask
	// ====
	// Clock and main sequence.
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	initial begin
		{rst_i, ce_i, wr_i, rd_i, offhook} = 5'b11000;
		addr_i = 8'h00;
		wdata_i = 16'h0000;
		dly = 16'h0000;
		fails = 0;
		comparisons = 0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wr(`A_DC_SHIFT, 16'h27CD);
		rd(`A_DC_SHIFT, d);
		chk(24'(d), 24'h27CD);
		rd(8'h30, d);
		chk(24'(d), 24'h0000);
		rd(`A_LINE_STATE, d);
		chk(24'(d), 24'h0000);
		$display("register test done");
		for (int s = 0; s < 2; s++) begin
			if (s == 0)
				prog(16'h0006, 16'h1000, 16'h0000, 16'h3F78, 16'h6CE8, 16'h0000, 16'h0000);
			else
				prog(16'h0007, 16'h0800, 16'h0040, 16'h0100, 16'h0000, 16'h0000, 16'h0000);
			wr(`A_LINE_STATE, 16'h0004);
			wait_ls(`LS_RINGING, 4, n);
			chk(24'(ring_relay_o), 24'h1);
			wait_ls(`LS_ONHOOK_TX, 5100, n);
			chk(24'(n > 2490 && n < 5010), 24'h1);
			wait_ls(`LS_RINGING, 5100, n);
			chk(24'(n > 2490 && n < 5010), 24'h1);
			wr(`A_CONTROL, 16'(s));
			series(8 + s, 16'h0020, ch, bad);
			chk(24'(s ? (bad == 0 && ch > 0) : ch == 1), 24'h1);
			wr(`A_LINE_STATE, 16'h0000);
			$display("shape %0d done", s);
		end
		prog(16'h0000, 16'h1000, 16'h0000, 16'h3F78, 16'h6CE8, 16'h27CD, 16'h0000);
		offhook <= 1'b1;
		dly <= 16'h0BB8;
		wr(`A_LINE_STATE, 16'h0004);
		wait_ls(`LS_ACTIVE, 3100, n);
		rd(`A_CONTROL, d);
		chk(24'(d[6:5]), 24'h1);
		wr(`A_CONTROL, 16'h0020);
		rd(`A_CONTROL, d);
		chk(24'(d[5]), 24'h0);
		dly <= 16'h0000;
		wr(`A_LINE_STATE, 16'h0004);
		wait_ls(`LS_RINGING, 4, n);
		wait_ls(`LS_ACTIVE, 8, n);
		chk(24'(ring_relay_o), 24'h0);
		offhook <= 1'b0;
		$display("trip test done");
		prog(16'h0008, 16'h1000, 16'h0000, 16'h3F78, 16'h6CE8, 16'h27CD, 16'h0100);
		wr(`A_LINE_STATE, 16'h0004);
		repeat (2600) @(posedge clk_i);
		#1;
		chk(24'(tip_level_o), 24'h0100);
		wr(`A_LINE_STATE, 16'h0000);
		prog(16'h0018, 16'h1000, 16'h0000, 16'h3F78, 16'h6CE8, 16'hD833, 16'h0100);
		wr(`A_LINE_STATE, 16'h0004);
		repeat (100) @(posedge clk_i);
		#1;
		r0 = ring_level_o;
		repeat (5000) @(posedge clk_i);
		#1;
		chk(24'(ring_level_o), 24'(r0));
		$display("lead test done");
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		chk(24'({line_state_o, ring_relay_o}), 24'h0);
		rd(`A_DC_SHIFT, d);
		chk(24'(d), 24'h0000);
		$display("reset test done");
		close_out();
	end
endmodule // tb_top
`default_nettype wire
